//--- rtl/lcdc_pkg.sv
// Purpose: shared constants, types and encodings of the character display command decoder
// Assumes: 50 MHz mclk, host drives the nibble interface from its own logic
// Notes: timing figures are kept in ns, cycle counts derive from the clock period
//
// Functional notes
// - bytes cross as two nibbles, upper first
// - strobe low: select, direction, data ignored
// - clear: fill blanks, counter zero, increment set
// - home: counter zero, undo shift, memory kept
// - entry bit 1 steps counter up or down
// - entry bit 0 shifts window on display memory writes
// - display bit blanks characters, memory kept
// - cursor bit shows underline cursor
// - blink bit toggles cursor every half second
// - shift command moves cursor or whole window
// - cursor wraps between lines, lines shift together
// - glyph address loads six bits, selects glyph memory
// - display address loads seven bits, selects display memory
// - status read returns busy and counter
// - one counter, target set by last address command or by clear
// - data write stores, steps, applies entry shift
// - data read returns byte, steps, never shifts
// - lines start at 0x00 and 0x40 unshifted
// - four data lines plus select, direction, strobe
package lcdc_pkg;
  // clock and execution times
  localparam int CLK_NS = 20;
  localparam int T_CLEAR_NS = 1640000;
  localparam int T_HOME_NS = 1600000;
  localparam int T_CMD_NS = 40000;
  localparam int T_BLINK_NS = 500000000;
  localparam int CYC_CLEAR = T_CLEAR_NS / CLK_NS;
  localparam int CYC_HOME = T_HOME_NS / CLK_NS;
  localparam int CYC_BLINK = T_BLINK_NS / CLK_NS;
  localparam int EXEC_W = 24;
  localparam logic [EXEC_W-1:0] CYC_CMD = EXEC_W'(T_CMD_NS / CLK_NS);
  // memory shape and layout
  localparam int DD_DEPTH = 128;
  localparam int CG_DEPTH = 64;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] CODE_BLANK = 8'h20;
  localparam logic [6:0] AC_HOME = 7'h00;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [5:0] LINE_LEN = 6'h28;
  localparam logic [5:0] SHIFT_HOME = 6'h00;
  // command field positions
  localparam int BIT_ID = 1;
  localparam int BIT_SH = 0;
  localparam int BIT_D = 2;
  localparam int BIT_C = 1;
  localparam int BIT_B = 0;
  localparam int BIT_SC = 3;
  localparam int BIT_RL = 2;
  // reset values of the options
  localparam logic RST_INC = 1'b1;
  localparam logic RST_OPT = 1'b0;
  // decoded operations
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_CLEAR = 4'h1, OP_HOME = 4'h2, OP_ENTRY = 4'h3,
    OP_DISP = 4'h4, OP_SHIFT = 4'h5, OP_FUNC = 4'h6, OP_SETCG = 4'h7,
    OP_SETDD = 4'h8, OP_WDAT = 4'h9, OP_RDAT = 4'ha
  } lcdc_op_e;
  // one assembled byte with its select and direction
  typedef struct packed {
    logic rs;
    logic rw;
    logic [7:0] data;
  } lcdc_cmd_s;
endpackage : lcdc_pkg

//--- rtl/lcdc_top.sv
// Purpose: nibble interface, command queue and executor of a two-line character display
// Assumes: host pins are asynchronous to mclk and are synchronised here
// Notes: memories are flip-flops; scan port reads what the panel would show
`timescale 1ns/1ps

// small flop fifo between byte assembly and the executor
module lcdc_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D]; // storage entries
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // write and read index
  logic [AW:0] cnt_r, cnt_nxt; // fill level
  logic push, pop;

  // pointer and level update
  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clk_en) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // entry write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (clk_en && push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
endmodule : lcdc_fifo

module lcdc_top import lcdc_pkg::*; #(
  parameter int CLEAR_CYC = CYC_CLEAR,
  parameter int HOME_CYC = CYC_HOME,
  parameter int BLINK_CYC = CYC_BLINK
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // host nibble interface
  input wire logic display_strobe,
  input wire logic register_select_line,
  input wire logic read_write_line,
  input wire logic [3:0] shared_data_nibble_in,
  output logic [3:0] shared_data_nibble_out,
  output logic shared_data_nibble_oe,
  // status
  output logic busy_indicator,
  output logic [6:0] addr_counter,
  output logic cmd_rejected,
  // display state
  output logic display_enable,
  output logic cursor_visible,
  output logic [5:0] display_shift,
  // panel scan
  input wire logic scan_line,
  input wire logic [3:0] scan_col,
  output logic [7:0] scan_char
);
  // pin synchronisers
  logic strb_s1_r, strb_s2_r, strb_s3_r, rs_s1_r, rs_s2_r, rw_s1_r, rw_s2_r;
  logic [3:0] nib_s1_r, nib_s2_r;
  // nibble interface state
  logic phase_r, phase_nxt; // 1 after upper nibble taken
  logic [3:0] hi_r, hi_nxt;
  logic rs_cap_r, rs_cap_nxt, rw_cap_r, rw_cap_nxt;
  logic [7:0] rd_byte_r, rd_byte_nxt;
  logic [3:0] nout_r, nout_nxt;
  logic noe_r, noe_nxt, rej_r, rej_nxt;
  logic strobe_rise, wr_push, fifo_in_ready, fifo_out_valid, pop;
  lcdc_cmd_s fifo_in, cmd;
  lcdc_op_e op;
  // executor state
  logic [6:0] ac_r, ac_nxt;
  logic cg_sel_r, cg_sel_nxt, inc_r, inc_nxt, esh_r, esh_nxt;
  logic disp_r, disp_nxt, cur_r, cur_nxt, blink_r, blink_nxt;
  logic [5:0] shift_r, shift_nxt;
  logic [EXEC_W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  // memory write controls
  logic dd_we, dd_clr, cg_we;
  logic [7:0] dd_mem_r [DD_DEPTH];
  logic [7:0] dd_nxt [DD_DEPTH];
  logic [7:0] cg_mem_r [CG_DEPTH];
  logic [7:0] cg_nxt [CG_DEPTH];
  logic [7:0] mem_rd;
  // blink and scan
  logic [24:0] bcnt_r, bcnt_nxt;
  logic bph_r, bph_nxt, cvis_r, cvis_nxt;
  logic [5:0] col_sum;
  logic [6:0] scan_addr;
  logic [7:0] scan_r, scan_nxt;

  // counter step with line wrap in display memory, plain wrap in glyph memory
  function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up, input logic cg);
    logic [6:0] r;
    r = a;
    if (cg) r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    else if (up) r = (a == LINE1_LAST) ? LINE2_BASE : (a == LINE2_LAST) ? AC_HOME : a + 7'h01;
    else r = (a == AC_HOME) ? LINE2_LAST : (a == LINE2_BASE) ? LINE1_LAST : a - 7'h01;
    return r;
  endfunction : step_ac

  // window offset modulo the line length, both lines share it
  function automatic logic [5:0] step_sh(input logic [5:0] s, input logic up);
    logic [5:0] r;
    r = s;
    if (up) r = (s == LINE_LEN - 6'h01) ? SHIFT_HOME : s + 6'h01;
    else r = (s == SHIFT_HOME) ? LINE_LEN - 6'h01 : s - 6'h01;
    return r;
  endfunction : step_sh

  // operation from the most significant set bit
  function automatic lcdc_op_e decode(input lcdc_cmd_s c);
    lcdc_op_e o;
    o = OP_NOP;
    if (c.rs) o = c.rw ? OP_RDAT : OP_WDAT;
    else if (c.rw) o = OP_NOP;
    else if (c.data[7]) o = OP_SETDD;
    else if (c.data[6]) o = OP_SETCG;
    else if (c.data[5]) o = OP_FUNC;
    else if (c.data[4]) o = OP_SHIFT;
    else if (c.data[3]) o = OP_DISP;
    else if (c.data[2]) o = OP_ENTRY;
    else if (c.data[1]) o = OP_HOME;
    else if (c.data[0]) o = OP_CLEAR;
    return o;
  endfunction : decode

  // two flops on every pin, third strobe flop only for the edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {strb_s1_r, strb_s2_r, strb_s3_r} <= 3'h0;
      {rs_s1_r, rs_s2_r, rw_s1_r, rw_s2_r} <= 4'h0;
      nib_s1_r <= 4'h0;
      nib_s2_r <= 4'h0;
    end else if (clk_en) begin
      {strb_s1_r, strb_s2_r, strb_s3_r} <= {display_strobe, strb_s1_r, strb_s2_r};
      {rs_s1_r, rs_s2_r} <= {register_select_line, rs_s1_r};
      {rw_s1_r, rw_s2_r} <= {read_write_line, rw_s1_r};
      nib_s1_r <= shared_data_nibble_in;
      nib_s2_r <= nib_s1_r;
    end
  end

  assign strobe_rise = strb_s2_r & ~strb_s3_r; // nibble, select and direction captured only on a strobe edge
  assign mem_rd = cg_sel_r ? cg_mem_r[ac_r[5:0]] : dd_mem_r[ac_r];

  // nibble assembly, read drive and rejection
  always_comb begin
    phase_nxt = phase_r;
    hi_nxt = hi_r;
    rs_cap_nxt = rs_cap_r;
    rw_cap_nxt = rw_cap_r;
    rd_byte_nxt = rd_byte_r;
    rej_nxt = 1'b0;
    wr_push = 1'b0;
    fifo_in = '{rs: rs_cap_r, rw: rw_cap_r, data: {hi_r, nib_s2_r}};
    if (strobe_rise) begin
      phase_nxt = ~phase_r;
      if (!phase_r) begin // upper nibble first
        hi_nxt = nib_s2_r;
        rs_cap_nxt = rs_s2_r;
        rw_cap_nxt = rw_s2_r;
        if (rw_s2_r) rd_byte_nxt = rs_s2_r ? mem_rd : {busy_r, ac_r};
      end else if (rs_cap_r || !rw_cap_r) begin // byte that needs the executor
        if (busy_r || !fifo_in_ready) rej_nxt = 1'b1;
        else wr_push = 1'b1;
      end
    end
    nout_nxt = phase_r ? rd_byte_r[7:4] : rd_byte_r[3:0];
    noe_nxt = strb_s2_r & rw_s2_r;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
      hi_r <= 4'h0;
      rs_cap_r <= 1'b0;
      rw_cap_r <= 1'b0;
      rd_byte_r <= 8'h00;
      nout_r <= 4'h0;
      noe_r <= 1'b0;
      rej_r <= 1'b0;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
      hi_r <= hi_nxt;
      rs_cap_r <= rs_cap_nxt;
      rw_cap_r <= rw_cap_nxt;
      rd_byte_r <= rd_byte_nxt;
      nout_r <= nout_nxt;
      noe_r <= noe_nxt;
      rej_r <= rej_nxt;
    end
  end

  // queue of accepted bytes
  lcdc_fifo #(.W($bits(lcdc_cmd_s)), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(wr_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(cnt_r == '0),
    .out_data(cmd)
  );

  assign pop = fifo_out_valid & (cnt_r == '0);
  assign op = decode(cmd);

  // command execution
  always_comb begin
    ac_nxt = ac_r;
    cg_sel_nxt = cg_sel_r;
    inc_nxt = inc_r;
    esh_nxt = esh_r;
    disp_nxt = disp_r;
    cur_nxt = cur_r;
    blink_nxt = blink_r;
    shift_nxt = shift_r;
    dd_we = 1'b0;
    cg_we = 1'b0;
    dd_clr = 1'b0;
    cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - EXEC_W'(1);
    if (pop) begin
      cnt_nxt = CYC_CMD;
      unique case (op)
        OP_CLEAR: begin
          dd_clr = 1'b1;
          ac_nxt = AC_HOME;
          inc_nxt = RST_INC;
          esh_nxt = RST_OPT;
          shift_nxt = SHIFT_HOME;
          cg_sel_nxt = 1'b0;
          cnt_nxt = EXEC_W'(CLEAR_CYC);
        end
        OP_HOME: begin
          ac_nxt = AC_HOME;
          shift_nxt = SHIFT_HOME;
          cnt_nxt = EXEC_W'(HOME_CYC);
        end
        OP_ENTRY: begin
          inc_nxt = cmd.data[BIT_ID];
          esh_nxt = cmd.data[BIT_SH];
        end
        OP_DISP: begin
          disp_nxt = cmd.data[BIT_D];
          cur_nxt = cmd.data[BIT_C];
          blink_nxt = cmd.data[BIT_B];
        end
        OP_SHIFT: begin
          if (cmd.data[BIT_SC]) shift_nxt = step_sh(shift_r, ~cmd.data[BIT_RL]);
          else ac_nxt = step_ac(ac_r, cmd.data[BIT_RL], cg_sel_r);
        end
        OP_FUNC, OP_NOP: begin // only busy time, no state
        end
        OP_SETCG: begin
          cg_sel_nxt = 1'b1;
          ac_nxt = {1'b0, cmd.data[5:0]};
        end
        OP_SETDD: begin
          cg_sel_nxt = 1'b0;
          ac_nxt = cmd.data[6:0];
        end
        OP_WDAT: begin
          cg_we = cg_sel_r;
          dd_we = ~cg_sel_r;
          ac_nxt = step_ac(ac_r, inc_r, cg_sel_r);
          if (!cg_sel_r && esh_r) shift_nxt = step_sh(shift_r, inc_r);
        end
        OP_RDAT: begin
          ac_nxt = step_ac(ac_r, inc_r, cg_sel_r);
        end
      endcase
    end
    busy_nxt = wr_push | (cnt_nxt != '0) | (fifo_out_valid & ~pop);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ac_r <= AC_HOME;
      cg_sel_r <= 1'b0;
      inc_r <= RST_INC;
      esh_r <= RST_OPT;
      disp_r <= RST_OPT;
      cur_r <= RST_OPT;
      blink_r <= RST_OPT;
      shift_r <= SHIFT_HOME;
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      ac_r <= ac_nxt;
      cg_sel_r <= cg_sel_nxt;
      inc_r <= inc_nxt;
      esh_r <= esh_nxt;
      disp_r <= disp_nxt;
      cur_r <= cur_nxt;
      blink_r <= blink_nxt;
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  // display memory entries
  for (genvar gi = 0; gi < DD_DEPTH; gi++) begin : g_dd
    always_comb begin
      dd_nxt[gi] = dd_mem_r[gi];
      if (dd_clr) dd_nxt[gi] = CODE_BLANK;
      else if (dd_we && ac_r == 7'(gi)) dd_nxt[gi] = cmd.data;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) dd_mem_r[gi] <= CODE_BLANK;
      else if (clk_en) dd_mem_r[gi] <= dd_nxt[gi];
    end
  end

  // glyph memory entries
  for (genvar gj = 0; gj < CG_DEPTH; gj++) begin : g_cg
    always_comb begin
      cg_nxt[gj] = cg_mem_r[gj];
      if (cg_we && ac_r[5:0] == 6'(gj)) cg_nxt[gj] = cmd.data;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) cg_mem_r[gj] <= 8'h00;
      else if (clk_en) cg_mem_r[gj] <= cg_nxt[gj];
    end
  end

  // cursor blink, shifted scan lookup
  always_comb begin
    bph_nxt = bph_r;
    bcnt_nxt = bcnt_r + 25'h0000001;
    if (bcnt_r >= 25'(BLINK_CYC - 1)) begin
      bcnt_nxt = '0;
      bph_nxt = ~bph_r;
    end
    cvis_nxt = cur_r & (~blink_r | bph_r);
    col_sum = {2'b00, scan_col} + shift_r;
    if (col_sum >= LINE_LEN) col_sum = col_sum - LINE_LEN;
    scan_addr = (scan_line ? LINE2_BASE : AC_HOME) | {1'b0, col_sum};
    scan_nxt = disp_r ? dd_mem_r[scan_addr] : CODE_BLANK;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_r <= '0;
      bph_r <= 1'b0;
      cvis_r <= 1'b0;
      scan_r <= CODE_BLANK;
    end else if (clk_en) begin
      bcnt_r <= bcnt_nxt;
      bph_r <= bph_nxt;
      cvis_r <= cvis_nxt;
      scan_r <= scan_nxt;
    end
  end

  assign shared_data_nibble_out = nout_r;
  assign shared_data_nibble_oe = noe_r;
  assign busy_indicator = busy_r;
  assign addr_counter = ac_r;
  assign cmd_rejected = rej_r;
  assign display_enable = disp_r;
  assign cursor_visible = cvis_r;
  assign display_shift = shift_r;
  assign scan_char = scan_r;

  // checks beside the logic
  AST_NIB_ORDER: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_push |-> phase_r && strobe_rise) else $error("byte queued off second nibble");
  AST_STROBE_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    !strb_s2_r |=> $stable(phase_r) && $stable(hi_r)) else $error("pins taken with strobe low");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && clk_en && op == OP_CLEAR)
    |=> ac_r == AC_HOME && inc_r && dd_mem_r[5] == CODE_BLANK && busy_r)
    else $error("clear left state behind");
  AST_HOME: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && clk_en && op == OP_HOME)
    |=> ac_r == AC_HOME && shift_r == SHIFT_HOME && $stable(dd_mem_r[0]))
    else $error("home did not restore position");
  AST_STEP_UP: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && clk_en && op == OP_WDAT && !cg_sel_r && inc_r && ac_r < LINE1_LAST)
    |=> ac_r == $past(ac_r) + 7'h01) else $error("counter not incremented");
  AST_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && clk_en && !cg_sel_r && ac_r == LINE1_LAST && ((op == OP_RDAT && inc_r)
    || (op == OP_SHIFT && !cmd.data[BIT_SC] && cmd.data[BIT_RL]))) |=> ac_r == LINE2_BASE)
    else $error("counter did not wrap to second line");
  AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && clk_en) |=> busy_r [*8]) else $error("busy dropped early");
  AST_REJECT: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && strobe_rise && phase_r && busy_r && (rs_cap_r || !rw_cap_r))
    |-> !wr_push ##1 rej_r) else $error("byte taken while busy");
  AST_READ_NOSHIFT: assert property (@(posedge mclk) disable iff (!rst_b)
    (pop && op == OP_RDAT) |=> $stable(shift_r)) else $error("read shifted window");
  AST_BLANK: assert property (@(posedge mclk) disable iff (!rst_b)
    (!disp_r && clk_en) |=> scan_char == CODE_BLANK) else $error("blanked display shows data");
  AST_STATUS: assert property (@(posedge mclk) disable iff (!rst_b)
    (strobe_rise && !phase_r && rw_s2_r && !rs_s2_r && clk_en) |=> rd_byte_r == {$past(busy_r), $past(ac_r)})
    else $error("status byte wrong");
endmodule : lcdc_top

//--- tb/lcdc_host_model.sv
// Purpose: host side of the nibble link, drives strobe, select, direction, data
// Assumes: pins change 1 ns after a rising mclk edge
// Notes: released data lines show the inverse of the last nibble
`timescale 1ns/1ps
module lcdc_host_model (
  // clock
  input wire logic mclk,
  // pins toward the device
  output logic strobe,
  output logic rs,
  output logic rw,
  output logic [3:0] nib,
  // read path from the device
  input wire logic [3:0] nib_out,
  input wire logic nib_oe
);
  // cycles per strobe phase, well over the pin minimum
  localparam int PH = 12;
  // idle pins at time zero
  initial begin
    strobe = 1'b0;
    rs = 1'b0;
    rw = 1'b0;
    nib = 4'h0;
  end
  // wait whole cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one strobe pulse; q is what the device drove while high
  task automatic pulse(input logic [3:0] d, output logic [3:0] q);
    nib = d;
    tick(3); // setup before strobe rises
    strobe = 1'b1;
    tick(PH - 2);
    q = (nib_oe === 1'b1) ? nib_out : 4'hx;
    tick(2);
    strobe = 1'b0;
    nib = ~d; // no kinder than a floating bus
    tick(PH); // spacing between nibbles and bytes
  endtask : pulse
  // one byte, upper nibble first
  task automatic xfer(input logic s, input logic r, input logic [7:0] d,
                      output logic [7:0] q);
    logic [3:0] hi;
    logic [3:0] lo;
    rs = s;
    rw = r;
    pulse(d[7:4], hi);
    pulse(d[3:0], lo);
    q = {hi, lo};
  endtask : xfer
  // pins move while strobe stays low
  task automatic wiggle();
    rs = 1'b1;
    nib = 4'h5;
    tick(5);
    rw = 1'b1;
    nib = 4'ha;
    tick(5);
    rs = 1'b0;
    rw = 1'b0;
  endtask : wiggle
endmodule : lcdc_host_model

//--- tb/lcdc_top_bench.sv
// Purpose: self-checking bench of the display command decoder
// Assumes: shortened clear, home and blink counts
// Notes: a sticky flag catches the one-cycle reject pulse
`timescale 1ns/1ps
module lcdc_top_bench import lcdc_pkg::*; ();
  // clock, reset and pins
  logic mclk, rst_b, en, strobe, rs, rw, oe, busy, rej, den, cur, sl, rej_seen;
  logic [3:0] nib, nib_out, sc;
  logic [6:0] ac;
  logic [5:0] dsh;
  logic [7:0] sch, q;
  int fail_count, cmp_count, cyc, n;
  lcdc_top #(.CLEAR_CYC(40), .HOME_CYC(40), .BLINK_CYC(16)) dut_u (
    .mclk(mclk), .rst_b(rst_b), .clk_en(en), .display_strobe(strobe),
    .register_select_line(rs), .read_write_line(rw), .shared_data_nibble_in(nib),
    .shared_data_nibble_out(nib_out), .shared_data_nibble_oe(oe),
    .busy_indicator(busy), .addr_counter(ac), .cmd_rejected(rej),
    .display_enable(den), .cursor_visible(cur), .display_shift(dsh),
    .scan_line(sl), .scan_col(sc), .scan_char(sch));
  lcdc_host_model host_u (.mclk(mclk), .strobe(strobe), .rs(rs), .rw(rw),
    .nib(nib), .nib_out(nib_out), .nib_oe(oe));
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // reject catcher and hang guard
  always @(posedge mclk) begin
    if (rej === 1'b1) rej_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      $display("timeout");
      finish_test();
    end
  end
  // verdict
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : check
  // poll busy under a bound, n holds the cycles waited
  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      host_u.tick(1); // look at busy once it has settled
      n++;
    end
    check("busy clears", 8'h00, {7'h0, busy});
  endtask : wait_idle
  task automatic wr(input logic s, input logic [7:0] d);
    host_u.xfer(s, 1'b0, d, q);
    wait_idle();
  endtask : wr
  task automatic scan(input logic [3:0] col, input logic [7:0] e);
    sl = 1'b0;
    sc = col;
    host_u.tick(3);
    check("scan char", e, sch);
  endtask : scan
  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done
  // main sequence
  initial begin
    rst_b = 1'b0;
    sl = 1'b0;
    sc = 4'h0;
    rej_seen = 1'b0;
    en = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1'b1;
    host_u.tick(2);
    check("reset busy", 8'h00, {7'h0, busy});
    check("reset shown", CODE_BLANK, sch);
    done("reset");
    host_u.xfer(1'b0, 1'b0, 8'h85, q);
    check("busy set", 8'h01, {7'h0, busy});
    wait_idle();
    check("busy span", 8'h01, {7'h0, n > 1950 && n < 2010});
    check("dd addr", 8'h05, {1'b0, ac});
    host_u.xfer(1'b0, 1'b1, 8'h00, q);
    check("status", 8'h05, q);
    wr(1'b0, 8'h28);
    check("func set", 8'h05, {1'b0, ac});
    done("address");
    wr(1'b0, 8'h06);
    wr(1'b0, 8'h0c);
    check("display on", 8'h01, {7'h0, den});
    wr(1'b1, 8'h41);
    check("ac inc", 8'h06, {1'b0, ac});
    scan(4'h5, 8'h41);
    wr(1'b0, 8'h08);
    scan(4'h5, 8'h20);
    wr(1'b0, 8'h0c);
    scan(4'h5, 8'h41);
    done("write");
    host_u.xfer(1'b0, 1'b0, 8'h8a, q);
    host_u.xfer(1'b0, 1'b0, 8'h90, q);
    wait_idle();
    check("reject seen", 8'h01, {7'h0, rej_seen});
    check("reject kept", 8'h0a, {1'b0, ac});
    done("reject");
    wr(1'b0, 8'h04);
    wr(1'b1, 8'h42);
    check("ac dec", 8'h09, {1'b0, ac});
    host_u.wiggle();
    host_u.tick(6);
    check("strobe low", 8'h09, {1'b0, ac});
    check("no busy", 8'h00, {7'h0, busy});
    done("decrement");
    wr(1'b0, 8'h18);
    check("win left", 8'h01, {2'h0, dsh});
    check("win ac", 8'h09, {1'b0, ac});
    wr(1'b0, 8'h10);
    check("cur left", 8'h08, {1'b0, ac});
    wr(1'b0, 8'h03);
    check("home shift", 8'h00, {2'h0, dsh});
    check("home ac", 8'h00, {1'b0, ac});
    scan(4'h5, 8'h41);
    wr(1'b0, 8'ha7);
    wr(1'b0, 8'h14);
    check("wrap", 8'h40, {1'b0, ac});
    done("shift");
    wr(1'b0, 8'h43);
    wr(1'b0, 8'h06);
    wr(1'b1, 8'h15);
    check("cg ac", 8'h04, {1'b0, ac});
    wr(1'b0, 8'h07);
    wr(1'b0, 8'h43);
    host_u.xfer(1'b1, 1'b1, 8'h00, q);
    check("cg read", 8'h15, q);
    wait_idle();
    check("rd step", 8'h04, {1'b0, ac});
    check("rd no shift", 8'h00, {2'h0, dsh});
    wr(1'b0, 8'h90);
    wr(1'b1, 8'h42);
    check("entry shift", 8'h01, {2'h0, dsh});
    check("entry ac", 8'h11, {1'b0, ac});
    done("glyph");
    wr(1'b0, 8'h05); // decrement with shift, so clear has work to undo
    wr(1'b0, 8'h01);
    check("clr ac", 8'h00, {1'b0, ac});
    check("clr shift", 8'h00, {2'h0, dsh});
    scan(4'h5, CODE_BLANK);
    wr(1'b1, 8'h30);
    check("clr inc", 8'h01, {1'b0, ac});
    check("clr no win", 8'h00, {2'h0, dsh});
    wr(1'b0, 8'h0e);
    check("cursor", 8'h01, {7'h0, cur});
    wr(1'b0, 8'h0f);
    n = 0;
    repeat (40) begin
      host_u.tick(1);
      if (cur === 1'b0) n++;
    end
    check("blink", 8'h01, {7'h0, n > 0 && n < 40});
    done("clear");
    // enable low: a whole byte passes unseen
    en = 1'b0;
    host_u.xfer(1'b0, 1'b0, 8'h80, q);
    check("frozen ac", 8'h01, {1'b0, ac});
    check("frozen busy", 8'h00, {7'h0, busy});
    en = 1'b1;
    host_u.tick(4);
    check("thawed ac", 8'h01, {1'b0, ac});
    // status read while the queued byte still executes
    host_u.xfer(1'b0, 1'b0, 8'h80, q);
    host_u.xfer(1'b0, 1'b1, 8'h00, q);
    check("busy status", 8'h80, q);
    wait_idle();
    // second line through the scan port
    wr(1'b0, 8'hc3);
    wr(1'b1, 8'h5a);
    sl = 1'b1;
    sc = 4'h3;
    host_u.tick(3);
    check("line two", 8'h5a, sch);
    sl = 1'b0;
    check("line two ac", 8'h44, {1'b0, ac});
    done("enable");
    finish_test();
  end
endmodule : lcdc_top_bench
